//--- rtl/qprc_pkg.sv
package qprc_pkg;
    // register offsets as printed; 016e and 0182 are not multiples of four, so each is an index
    localparam logic [15:0] QPRC_IDX_SLV_EN_LO   = 16'h016e;
    localparam logic [15:0] QPRC_IDX_ROUTE_UP    = 16'h0178;
    localparam logic [15:0] QPRC_IDX_MODE        = 16'h0180;
    localparam logic [15:0] QPRC_IDX_MAST_EN_LO  = 16'h0182;
    localparam logic [15:0] QPRC_IDX_PORT_MAP    = 16'h0184;
    localparam int          QPRC_ADDR_W          = 12;
    localparam int          QPRC_REG_W           = 16;
    localparam logic [15:0] QPRC_RST_VAL         = 16'h0000;
    // mode register fields
    localparam int          QPRC_MODE_SHARED_BIT = 0;
    localparam int          QPRC_MODE_P32_BIT    = 1;
    // queue geometry
    localparam int          QPRC_GROUP_SIZE      = 4;
    localparam int          QPRC_ROUTE_BASE_Q    = 48;
    localparam int          QPRC_SHARED_MAX_Q    = 32;
    localparam int          QPRC_NUM_QUEUES      = 64;
    localparam int          QPRC_PORT_W          = 5;
    localparam int          QPRC_QUEUE_W         = 6;
endpackage

//--- rtl/qprc_reg16.sv
`timescale 1ns/1ns
module qprc_reg16
    import qprc_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // write port
    input  wire logic                  wr_en,
    input  wire logic [1:0]            wr_sel,
    input  wire logic [QPRC_REG_W-1:0] wr_data,
    // stored value
    output logic      [QPRC_REG_W-1:0] value_q
);
    logic [QPRC_REG_W-1:0] value_d;

    // byte lanes merge into the held value
    assign value_d = {wr_sel[1] ? wr_data[15:8] : value_q[15:8],
                      wr_sel[0] ? wr_data[7:0]  : value_q[7:0]};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            value_q <= QPRC_RST_VAL;
        end else if (wr_en) begin
            value_q <= value_d;
        end
    end
endmodule

//--- rtl/qprc_route_lookup.sv
`timescale 1ns/1ns
module qprc_route_lookup
    import qprc_pkg::*;
(
    // query
    input  wire logic [QPRC_QUEUE_W-1:0] queue_id,
    input  wire logic [QPRC_REG_W-1:0]   route_bits,
    input  wire logic                    ports32_en,
    // answer
    output logic      [QPRC_PORT_W-1:0]  port_id,
    output logic                         route_valid
);
    wire                    in_upper = (queue_id >= QPRC_QUEUE_W'(QPRC_ROUTE_BASE_Q));
    wire [3:0]              bit_idx  = queue_id[3:0];
    wire [3:0]              group    = queue_id[5:2];
    wire                    odd_sel  = route_bits[bit_idx];

    // group g feeds ports 2g and 2g+1
    assign port_id     = {group, ports32_en & odd_sel};
    assign route_valid = ports32_en & in_upper;
endmodule

//--- rtl/qprc_top.sv
`timescale 1ns/1ns
// Behaviour
// - slave queue-enable bits take effect only while shared mode is on.
// - shared mode covers queues 0 to 15 only.
// - slave enable bit n stands for slave queue n, bits 0 to 15.
// - a one marks the slave queue enabled for sharing, zero not.
// - upper routing bits act only when 32 ports are configured.
// - upper routing bit 0 is queue 48, bit 15 is queue 63.
// - queues form sixteen groups of four, group g feeds ports 2g and 2g+1.
// - routing bit zero picks the even port, one picks the odd port.
// - master enable bits mark local queues shared, one meaning enabled.
module qprc_top
    import qprc_pkg::*;
(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [QPRC_ADDR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    // queue enable query
    input  wire logic [QPRC_QUEUE_W-1:0] enq_queue_id,
    output logic                         slave_q_shared,
    output logic                         master_q_shared,
    // route query
    input  wire logic [QPRC_QUEUE_W-1:0] route_queue_id,
    output logic      [QPRC_PORT_W-1:0]  route_port,
    output logic                         route_valid,
    // configuration views
    output logic                         shared_mode,
    output logic                         ports32_mode
);
    logic [QPRC_REG_W-1:0] slv_en_q;
    logic [QPRC_REG_W-1:0] route_q;
    logic [QPRC_REG_W-1:0] mode_q;
    logic [QPRC_REG_W-1:0] mast_en_q;
    logic                  ack_q;
    logic                  err_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;

    // decode
    wire        req      = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
    wire [11:0] idx      = 12'(wb_adr_i >> 2);
    wire        aligned  = (wb_adr_i[1:0] == 2'b00);
    wire        hit_slv  = aligned & (idx == QPRC_IDX_SLV_EN_LO[11:0]);
    wire        hit_rte  = aligned & (idx == QPRC_IDX_ROUTE_UP[11:0]);
    wire        hit_mode = aligned & (idx == QPRC_IDX_MODE[11:0]);
    wire        hit_mast = aligned & (idx == QPRC_IDX_MAST_EN_LO[11:0]);
    wire        hit_map  = aligned & (idx == QPRC_IDX_PORT_MAP[11:0]);
    wire        hit_any  = hit_slv | hit_rte | hit_mode | hit_mast | hit_map;
    wire        wr       = req & wb_we_i & hit_any;
    wire [1:0]  sel16    = wb_sel_i[1:0];

    assign rdata_d = hit_slv  ? {16'h0000, slv_en_q}  :
                     hit_rte  ? {16'h0000, route_q}   :
                     hit_mode ? {16'h0000, mode_q}    :
                     hit_mast ? {16'h0000, mast_en_q} :
                     hit_map  ? {16'h0000, 11'h000, route_port} :
                                32'h0000_0000;

    qprc_reg16 u_slv (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (wr & hit_slv),
        .wr_sel   (sel16),
        .wr_data  (wb_dat_i[15:0]),
        .value_q  (slv_en_q)
    );
    qprc_reg16 u_rte (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (wr & hit_rte),
        .wr_sel   (sel16),
        .wr_data  (wb_dat_i[15:0]),
        .value_q  (route_q)
    );
    qprc_reg16 u_mode (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (wr & hit_mode),
        .wr_sel   (sel16),
        .wr_data  (wb_dat_i[15:0]),
        .value_q  (mode_q)
    );
    qprc_reg16 u_mast (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (wr & hit_mast),
        .wr_sel   (sel16),
        .wr_data  (wb_dat_i[15:0]),
        .value_q  (mast_en_q)
    );

    // bus answer, one cycle after request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req & hit_any;
            err_q   <= req & ~hit_any;
            if (req & ~wb_we_i) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;

    assign shared_mode  = mode_q[QPRC_MODE_SHARED_BIT];
    assign ports32_mode = mode_q[QPRC_MODE_P32_BIT];

    // queue enable views
    wire in_low  = (enq_queue_id < QPRC_QUEUE_W'(16));
    wire in_shr  = (enq_queue_id < QPRC_QUEUE_W'(QPRC_SHARED_MAX_Q));
    assign slave_q_shared  = shared_mode & in_low & slv_en_q[enq_queue_id[3:0]];
    assign master_q_shared = shared_mode & in_shr & in_low
                             & mast_en_q[enq_queue_id[3:0]];

    qprc_route_lookup u_lookup (
        .queue_id    (route_queue_id),
        .route_bits  (route_q),
        .ports32_en  (ports32_mode),
        .port_id     (route_port),
        .route_valid (route_valid)
    );
endmodule

//--- tb/qprc_checker.sv
`timescale 1ns/1ns
module qprc_checker
    import qprc_pkg::*;
(
    // clock and reset
    input wire logic                    core_clk,
    input wire logic                    resetn,
    // bus
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_ack_o,
    input wire logic                    wb_err_o,
    // queries
    input wire logic [QPRC_QUEUE_W-1:0] enq_queue_id,
    input wire logic                    slave_q_shared,
    input wire logic                    master_q_shared,
    input wire logic [QPRC_QUEUE_W-1:0] route_queue_id,
    input wire logic [QPRC_PORT_W-1:0]  route_port,
    input wire logic                    route_valid,
    input wire logic                    shared_mode,
    input wire logic                    ports32_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_answer;
        (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    a_bus_answer_once: assert property (s_take |=> s_answer)
        else $error("bus answer missing or long");
    a_ack_err_apart: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_slave_mode_gate: assert property (!shared_mode |-> !slave_q_shared)
        else $error("slave enable outside shared mode");
    a_slave_queue_range: assert property (enq_queue_id >= 16 |-> !slave_q_shared)
        else $error("slave enable out of range");
    a_master_gate: assert property (!shared_mode || enq_queue_id >= 16 |-> !master_q_shared)
        else $error("master enable gate");
    a_route_group_map: assert property (route_port[4:1] == route_queue_id[5:2])
        else $error("route group wrong");
    a_route_mode_gate: assert property (!ports32_mode |-> !route_port[0] && !route_valid)
        else $error("routing outside 32 ports");
    a_route_valid_span: assert property (route_valid == (ports32_mode && route_queue_id >= 48))
        else $error("route valid span");
endmodule
bind qprc_top qprc_checker u_checker (.*);

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        core_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, e;
    logic [11:0] wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 0, sel = 4'h3;
    logic [31:0] wb_dat_i = 0, wb_dat_o, r;
    logic [5:0]  enq_queue_id = 0, route_queue_id = 0;
    logic [4:0]  route_port;
    logic [15:0] sv = 16'ha5c3, mv = 16'h3c5a, rv = 16'haaaa;
    logic        wb_ack_o, wb_err_o, slave_q_shared, master_q_shared, route_valid;
    logic        shared_mode, ports32_mode;
    int          n_mismatch = 0, tests_run = 0, n;
    qprc_top DUT (.*);
    initial forever #25 core_clk = ~core_clk;
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [11:0] a, input logic w, input logic [15:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, d};
        for (n = 0; n < 20 && wb_ack_o !== 1 && wb_err_o !== 1; n++) @(posedge core_clk);
        if (n == 20) begin
            n_mismatch++;
            $display("[ERR] %0t no bus answer", $time);
        end
        r = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task automatic q(input logic [5:0] id);
        @(posedge core_clk);
        enq_queue_id   <= id;
        route_queue_id <= id;
        @(negedge core_clk);
    endtask
    initial begin
        repeat (2000) @(posedge core_clk);
        n_mismatch++;
        $display("[ERR] %0t timeout", $time);
        conclude;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1;
        wb(12'h5b8, 0, 0); chk(r, 0);
        wb(12'h5e0, 0, 0); chk(r, 0);
        wb(12'h5b8, 1, sv);
        wb(12'h5e0, 1, rv);
        wb(12'h608, 1, mv);
        wb(12'h600, 1, 16'h0003);
        wb(12'h5b8, 0, 0); chk(r, 32'h0000_a5c3);
        wb(12'h5e0, 0, 0); chk(r, 32'h0000_aaaa);
        wb(12'h600, 0, 0); chk(r, 32'h0000_0003);
        wb(12'h608, 0, 0); chk(r, 32'h0000_3c5a);
        chk({shared_mode, ports32_mode}, 2'b11);
        wb(12'h7fc, 1, 16'hffff); chk(e, 1);
        wb(12'h7fc, 0, 0); chk(e, 1);
        chk(r, 0);
        wb(12'h5b9, 1, 16'hffff); chk(e, 1);
        wb(12'h5b8, 0, 0); chk(r, 32'h0000_a5c3);
        for (int i = 0; i < 64; i++) begin
            q(i);
            chk(slave_q_shared, i < 16 && sv[i[3:0]]);
            chk(master_q_shared, i < 16 && mv[i[3:0]]);
            chk({route_valid, route_port}, {i >= 48, i[5:2], rv[i[3:0]]});
        end
        q(6'h33); wb(12'h610, 0, 0); chk(r, 32'h0000_0019);
        wb(12'h600, 1, 0);
        q(6'h00); chk({slave_q_shared, master_q_shared}, 0);
        q(6'h31); chk({route_valid, route_port}, 6'h18);
        sel = 4'h2;
        wb(12'h5b8, 1, 16'h1234);
        sel = 4'h3;
        wb(12'h5b8, 0, 0); chk(r, 32'h0000_12c3);
        @(posedge core_clk);
        resetn <= 0;
        repeat (2) @(posedge core_clk);
        resetn <= 1;
        wb(12'h5b8, 0, 0); chk(r, 0);
        wb(12'h5e0, 0, 0); chk(r, 0);
        wb(12'h600, 0, 0); chk(r, 0);
        chk({shared_mode, ports32_mode}, 0);
        conclude;
    end
endmodule
